// File: design/apw_audio_pwm_output.sv
// audio pwm output stage with axi4-lite register slave
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - at each period boundary load, set the interrupt flag to one
// - copy held sample to active register at period end, and every cycle while disabled
// - without a new write, previous sample repeats next period
// - enable bit set starts pulses, cleared stops them
// - while disabled but not halted, with a drive-strength fuse set, both audio pins are driven low
// - halt clears enable and floats both audio pins
// - 10-bit mode runs 32 kHz, magnitudes 0 to 511
// - 10-bit sample is high nibble, low nibble, extra low bits 3:2
// - 12-bit mode runs 32 kHz, magnitudes up to 2047
// - 12-bit sample is high, low, extra low nibbles msb first
// - both drive-strength fuses zero floats pins regardless of enable
// - top bit of high nibble is sign, one means negative
// - in 8-bit mode seven bits below sign give pulse width
// - 8-bit mode also runs at fixed 32 kHz
// - one interrupt request each completed output period
module apw_audio_pwm_output
  import apw_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic res12_fuse,
  input wire logic res10_fuse,
  input wire logic drive_strength_fuse_a,
  input wire logic drive_strength_fuse_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic audio_pos_pin_o,
  output logic audio_pos_pin_oe_n,
  output logic audio_neg_pin_o,
  output logic audio_neg_pin_oe_n,
  output logic sample_irq_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // resolution decode and sample assembly

  function automatic apw_res_t res_sel(input logic f12, input logic f10);
    if (f12) begin
      return APW_RES12;
    end
    return f10 ? APW_RES10 : APW_RES8;
  endfunction

  function automatic apw_sample_t build_sample(input apw_res_t res, input logic [3:0] hi,
                                               input logic [3:0] lo, input logic [3:0] xl);
    apw_sample_t s;
    s.sign = hi[3];
    s.width = 11'h000;
    unique case (res)
      APW_RES8: s.width = {4'h0, hi[2:0], lo};
      APW_RES10: s.width = {2'h0, hi[2:0], lo, xl[3:2]};
      APW_RES12: s.width = {hi[2:0], lo, xl};
      default: s.width = 11'h000;
    endcase
    return s;
  endfunction

  apw_res_t res;
  assign res = res_sel(res12_fuse, res10_fuse);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [3:0] hi_r, hi_nxt, lo_r, lo_nxt, xl_r, xl_nxt;
  logic en_r, en_nxt, irq_r, irq_nxt, halted_r, halted_nxt;
  logic [9:0] cnt_r, cnt_nxt;
  apw_sample_t act_r, act_nxt;
  logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [7:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  apw_pins_t pins_r, pins_nxt;

  logic wr_go, rd_go, period_end, drive_ok;
  assign wr_go = aw_ok_r && w_ok_r && !bv_r;
  assign rd_go = s_axi_arvalid && !rv_r;
  assign period_end = (cnt_r == APW_PERIOD_LAST);
  assign drive_ok = drive_strength_fuse_a | drive_strength_fuse_b;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    hi_nxt = hi_r;
    lo_nxt = lo_r;
    xl_nxt = xl_r;
    en_nxt = en_r;
    irq_nxt = irq_r;
    halted_nxt = halted_r;
    cnt_nxt = cnt_r;
    act_nxt = act_r;
    aw_ok_nxt = aw_ok_r;
    w_ok_nxt = w_ok_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    bv_nxt = bv_r;
    bresp_nxt = bresp_r;
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rresp_nxt = rresp_r;
    pins_nxt = pins_r;

    // axi write channels taken in either order
    if (s_axi_awvalid && !aw_ok_r) begin
      aw_ok_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_ok_r) begin
      w_ok_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
    end
    if (bv_r && s_axi_bready) begin
      bv_nxt = 1'b0;
    end
    if (wr_go) begin
      aw_ok_nxt = 1'b0;
      w_ok_nxt = 1'b0;
      bv_nxt = 1'b1;
      bresp_nxt = APW_RESP_OKAY;
      unique case (awa_r)
        APW_OFS_STATUS: begin
          // software clears flag by writing zero
          if (!wd_r[APW_BIT_IRQ]) begin
            irq_nxt = 1'b0;
          end
        end
        APW_OFS_CTRL: begin
          en_nxt = wd_r[APW_BIT_EN];
          if (wd_r[APW_BIT_EN]) begin
            halted_nxt = 1'b0;
          end
        end
        APW_OFS_XLOW: xl_nxt = wd_r[3:0];
        APW_OFS_LOW: lo_nxt = wd_r[3:0];
        APW_OFS_HIGH: hi_nxt = wd_r[3:0];
        APW_OFS_HALT: begin
          // halt clears enable and floats pins
          if (wd_r[0]) begin
            en_nxt = 1'b0;
            halted_nxt = 1'b1;
          end
        end
        default: bresp_nxt = APW_RESP_SLVERR;
      endcase
    end

    // axi read
    if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
    if (rd_go) begin
      rv_nxt = 1'b1;
      rresp_nxt = APW_RESP_OKAY;
      rd_nxt = 32'h0000_0000;
      unique case (s_axi_araddr)
        APW_OFS_STATUS: rd_nxt[APW_BIT_IRQ] = irq_r;
        APW_OFS_CTRL: begin
          rd_nxt[APW_BIT_EN] = en_r;
          rd_nxt[APW_BIT_HALTED] = halted_r;
        end
        APW_OFS_XLOW: rd_nxt[3:0] = xl_r;
        APW_OFS_LOW: rd_nxt[3:0] = lo_r;
        APW_OFS_HIGH: rd_nxt[3:0] = hi_r;
        APW_OFS_HALT: rd_nxt = 32'h0000_0000;
        APW_OFS_LEVEL: rd_nxt[11:0] = act_r;
        default: rresp_nxt = APW_RESP_SLVERR;
      endcase
    end

    // pwm period counter; stopped counter restarts a fresh period
    if (en_r) begin
      cnt_nxt = period_end ? 10'h000 : 10'(cnt_r + 10'h001);
      if (period_end) begin
        act_nxt = build_sample(res, hi_r, lo_r, xl_r);
        irq_nxt = 1'b1;
      end
    end else begin
      cnt_nxt = 10'h000;
      // first period after enable uses freshly written data
      act_nxt = build_sample(res, hi_r, lo_r, xl_r);
    end

    // sign selects pin, width sets pulse length
    // fixed 32 kHz period; a 12-bit width above 780 holds the pin high all period
    pins_nxt.pos_o = en_r && !act_r.sign && ({1'b0, cnt_r} < act_r.width);
    pins_nxt.neg_o = en_r && act_r.sign && ({1'b0, cnt_r} < act_r.width);
    pins_nxt.pos_oe_n = halted_r || !drive_ok;
    pins_nxt.neg_oe_n = halted_r || !drive_ok;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_r <= APW_RST_NIBBLE;
      lo_r <= APW_RST_NIBBLE;
      xl_r <= APW_RST_NIBBLE;
      en_r <= 1'b0;
      irq_r <= 1'b0;
      halted_r <= 1'b0;
      cnt_r <= 10'h000;
      act_r <= APW_RST_SAMPLE;
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awa_r <= 8'h00;
      wd_r <= 32'h0000_0000;
      bv_r <= 1'b0;
      bresp_r <= APW_RESP_OKAY;
      rv_r <= 1'b0;
      rd_r <= 32'h0000_0000;
      rresp_r <= APW_RESP_OKAY;
      pins_r <= 4'b0000;
    end else if (clk_en) begin
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
      xl_r <= xl_nxt;
      en_r <= en_nxt;
      irq_r <= irq_nxt;
      halted_r <= halted_nxt;
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
      aw_ok_r <= aw_ok_nxt;
      w_ok_r <= w_ok_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      bv_r <= bv_nxt;
      bresp_r <= bresp_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
      rresp_r <= rresp_nxt;
      pins_r <= pins_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // handshake readies gated by clk_en so nothing is taken while frozen
  assign s_axi_awready = clk_en && !aw_ok_r;
  assign s_axi_wready = clk_en && !w_ok_r;
  assign s_axi_arready = clk_en && !rv_r;
  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rdata = rd_r;
  assign s_axi_rresp = rresp_r;
  assign audio_pos_pin_o = pins_r.pos_o;
  assign audio_pos_pin_oe_n = pins_r.pos_oe_n;
  assign audio_neg_pin_o = pins_r.neg_o;
  assign audio_neg_pin_oe_n = pins_r.neg_oe_n;
  assign sample_irq_flag = irq_r;

endmodule
`default_nettype wire

// File: pkg/apw_pkg.sv
// package: register map, field layout and timing constants of the audio pwm output
package apw_pkg;
  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] APW_OFS_STATUS = 8'h00;
  localparam logic [7:0] APW_OFS_CTRL = 8'h04;
  localparam logic [7:0] APW_OFS_XLOW = 8'h08;
  localparam logic [7:0] APW_OFS_LOW = 8'h0c;
  localparam logic [7:0] APW_OFS_HIGH = 8'h10;
  localparam logic [7:0] APW_OFS_HALT = 8'h14;
  localparam logic [7:0] APW_OFS_LEVEL = 8'h18;
  // field positions
  localparam int APW_BIT_IRQ = 2;
  localparam int APW_BIT_EN = 0;
  localparam int APW_BIT_HALTED = 1;
  // reset values
  localparam logic [3:0] APW_RST_NIBBLE = 4'h0;
  localparam logic [11:0] APW_RST_SAMPLE = 12'h000;
  // output period
  localparam int APW_CLK_HZ = 25000000;
  localparam int APW_RATE_HZ = 32000;
  localparam int APW_PERIOD_CYC = APW_CLK_HZ / APW_RATE_HZ;
  localparam logic [9:0] APW_PERIOD_LAST = 10'(APW_PERIOD_CYC - 1);
  // axi responses
  localparam logic [1:0] APW_RESP_OKAY = 2'b00;
  localparam logic [1:0] APW_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    APW_RES8 = 2'b00,
    APW_RES10 = 2'b01,
    APW_RES12 = 2'b10
  } apw_res_t;

  typedef struct packed {
    logic sign;
    logic [10:0] width;
  } apw_sample_t;

  typedef struct packed {
    logic pos_o;
    logic pos_oe_n;
    logic neg_o;
    logic neg_oe_n;
  } apw_pins_t;
endpackage

// File: test/apw_properties.sv
// checker: pin, flag and bus timing of the audio pwm output
`timescale 1ns/10ps
`default_nettype none
module apw_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic drive_strength_fuse_a,
  input wire logic drive_strength_fuse_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic audio_pos_pin_o,
  input wire logic audio_pos_pin_oe_n,
  input wire logic audio_neg_pin_o,
  input wire logic audio_neg_pin_oe_n,
  input wire logic sample_irq_flag
);
  logic [9:0] gap_r, gap_nxt;
  logic any_r, any_nxt, bv_r;
  // gap saturates, so a first pulse after reset never looks early
  always_comb begin
    any_nxt = audio_pos_pin_o | audio_neg_pin_o;
    gap_nxt = (gap_r == 10'h3ff) ? gap_r : gap_r + 10'h001;
    if (any_nxt && !any_r) gap_nxt = 10'h000;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r <= 10'h3ff;
      any_r <= 1'b0;
      bv_r <= 1'b0;
    end else begin
      gap_r <= gap_nxt;
      any_r <= any_nxt;
      bv_r <= s_axi_bvalid;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_pins_exclusive: assert property (!(audio_pos_pin_o && audio_neg_pin_o))
    else $error("both audio pins high");
  a_fuse_float: assert property ((!drive_strength_fuse_a && !drive_strength_fuse_b) [*3]
    |-> audio_pos_pin_oe_n && audio_neg_pin_oe_n) else $error("pins driven with fuses zero");
  a_oe_paired: assert property (audio_pos_pin_oe_n == audio_neg_pin_oe_n)
    else $error("pin enables differ");
  a_pulse_spacing: assert property (any_nxt && !any_r |-> gap_r >= 10'h30c)
    else $error("pulses closer than one period");
  a_flag_sticky: assert property ($fell(sample_irq_flag) |-> s_axi_bvalid || bv_r)
    else $error("flag fell without a write");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("no write response");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
endmodule
bind apw_audio_pwm_output apw_properties i_apw_properties (.*);
`default_nettype wire

// File: test/apw_speaker_model.sv
// loudspeaker model: resolves pad levels and measures pulses
`timescale 1ns/10ps
`default_nettype none
module apw_speaker_model (
  input wire logic clk,
  input wire logic pos_o,
  input wire logic pos_oe_n,
  input wire logic neg_o,
  input wire logic neg_oe_n,
  output logic [11:0] pos_len,
  output logic [11:0] neg_len,
  output logic [7:0] neg_n,
  output logic floated
);
  // a released pad floats, no pull on the speaker side
  wire pos_w = pos_oe_n ? 1'bz : pos_o;
  wire neg_w = neg_oe_n ? 1'bz : neg_o;
  logic [11:0] rp = 12'h000, rn = 12'h000;
  initial neg_n = 8'h00;
  always @(posedge clk) begin
    floated <= (pos_w === 1'bz) && (neg_w === 1'bz);
    rp <= (pos_w === 1'b1) ? rp + 12'h001 : 12'h000;
    rn <= (neg_w === 1'b1) ? rn + 12'h001 : 12'h000;
    if (pos_w !== 1'b1 && rp != 12'h000) pos_len <= rp;
    if (neg_w !== 1'b1 && rn != 12'h000) begin
      neg_len <= rn;
      neg_n <= neg_n + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: test/apw_audio_pwm_output_test.sv
// bench: registers, pulse widths and pin states of the audio pwm output
`timescale 1ns/10ps
`default_nettype none
module apw_audio_pwm_output_test;
  import apw_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, res12_fuse = 1'b0, res10_fuse = 1'b0;
  logic drive_strength_fuse_a = 1'b1, drive_strength_fuse_b = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sample_irq_flag;
  logic audio_pos_pin_o, audio_pos_pin_oe_n, audio_neg_pin_o, audio_neg_pin_oe_n, fl;
  logic [11:0] pl, nl;
  logic [7:0] nn;
  int bad_count = 0, checked = 0, cyc = 0;
  apw_audio_pwm_output i_apw_audio_pwm_output (.*);
  apw_speaker_model i_apw_speaker_model (.clk(aclk), .pos_o(audio_pos_pin_o),
    .pos_oe_n(audio_pos_pin_oe_n), .neg_o(audio_neg_pin_o), .neg_oe_n(audio_neg_pin_oe_n),
    .pos_len(pl), .neg_len(nl), .neg_n(nn), .floated(fl));
  always #20 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard, the full run needs well under 10000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [1:0] er, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    chk(n, e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic wflag(output int t);
    wr(APW_OFS_STATUS, 32'h0, APW_RESP_OKAY);
    repeat (2) @(posedge aclk);
    do @(posedge aclk); while (sample_irq_flag !== 1'b1);
    t = cyc;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc("ctrl", APW_OFS_CTRL, APW_RESP_OKAY, 32'h0);
    rdc("status", APW_OFS_STATUS, APW_RESP_OKAY, 32'h0);
    chk("pins", 32'h0, {audio_pos_pin_o, audio_pos_pin_oe_n, audio_neg_pin_o, audio_neg_pin_oe_n});
    wr(8'h1c, 32'h1, APW_RESP_SLVERR);
    rdc("unmapped", 8'h1c, APW_RESP_SLVERR, 32'h0);
  endtask
  task automatic t_modes();
    logic [13:0] tab[4] = '{{2'b00, 12'h835}, {2'b01, 12'h8d7}, {2'b11, 12'hb5c}, {2'b10, 12'hb5c}};
    wr(APW_OFS_HIGH, 32'hb, APW_RESP_OKAY);
    wr(APW_OFS_LOW, 32'h5, APW_RESP_OKAY);
    wr(APW_OFS_XLOW, 32'hc, APW_RESP_OKAY);
    foreach (tab[i]) begin
      {res12_fuse, res10_fuse} <= tab[i][13:12];
      rdc("sample", APW_OFS_LEVEL, APW_RESP_OKAY, {20'h0, tab[i][11:0]});
    end
  endtask
  task automatic t_pwm();
    int t1, t2;
    logic [7:0] n0;
    {res12_fuse, res10_fuse} <= 2'b00;
    wr(APW_OFS_HIGH, 32'h0, APW_RESP_OKAY);
    wr(APW_OFS_LOW, 32'h5, APW_RESP_OKAY);
    wr(APW_OFS_CTRL, 32'h1, APW_RESP_OKAY);
    wflag(t1);
    wflag(t2);
    chk("period", 32'h30d, t2 - t1);
    chk("pos width", 32'h5, {20'h0, pl});
    rdc("flag", APW_OFS_STATUS, APW_RESP_OKAY, 32'h4);
    wr(APW_OFS_HIGH, 32'h8, APW_RESP_OKAY);
    wr(APW_OFS_LOW, 32'h3, APW_RESP_OKAY);
    rdc("held", APW_OFS_LEVEL, APW_RESP_OKAY, 32'h005);
    wflag(t1);
    rdc("loaded", APW_OFS_LEVEL, APW_RESP_OKAY, 32'h803);
    repeat (20) @(posedge aclk);
    n0 = nn;
    wflag(t1);
    wflag(t1);
    repeat (20) @(posedge aclk);
    chk("neg reuse", {24'h0, n0 + 8'h02}, {24'h0, nn});
    chk("neg width", 32'h3, {20'h0, nl});
  endtask
  task automatic t_off();
    logic [7:0] n0;
    wr(APW_OFS_CTRL, 32'h0, APW_RESP_OKAY);
    n0 = nn;
    repeat (800) @(posedge aclk);
    chk("off pulses", {24'h0, n0}, {24'h0, nn});
    chk("off pins", 32'h0, {audio_pos_pin_o, audio_pos_pin_oe_n, audio_neg_pin_o, audio_neg_pin_oe_n});
    wr(APW_OFS_CTRL, 32'h1, APW_RESP_OKAY);
    repeat (20) @(posedge aclk);
    wr(APW_OFS_HALT, 32'h1, APW_RESP_OKAY);
    rdc("halt ctrl", APW_OFS_CTRL, APW_RESP_OKAY, 32'h2);
    chk("halt float", 32'h1, {31'h0, fl});
  endtask
  task automatic t_fuse();
    repeat (800) @(posedge aclk);
    {drive_strength_fuse_a, drive_strength_fuse_b} <= 2'b00;
    wr(APW_OFS_CTRL, 32'h1, APW_RESP_OKAY);
    repeat (5) @(posedge aclk);
    chk("fuse float", 32'h1, {31'h0, fl});
    for (int i = 1; i < 4; i++) begin
      {drive_strength_fuse_a, drive_strength_fuse_b} <= 2'(i);
      repeat (5) @(posedge aclk);
      chk("fuse drive", 32'h0, {31'h0, fl});
    end
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_modes();
    t_pwm();
    t_off();
    t_fuse();
    wrap_up();
  end
endmodule
`default_nettype wire
